// file: src/ssdr_pkg.sv
// package: register map, field positions and types of the serial status/data block
package ssdr_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_OVR  = 5;
  localparam int BIT_MODE_FAULT_FLAG = 4;
  localparam int BIT_RSVD = 3;
  localparam int BIT_SOD  = 2;
  localparam int BIT_SSM  = 1;
  localparam int BIT_SSI  = 0;
  localparam int BIT_IRQE = 7;
  localparam int BIT_PEN  = 6;
  localparam int BIT_MSTR = 4;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] STAT_RST   = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hff;
  localparam logic [7:0] STAT_WMASK = 8'h07;
  localparam logic [3:0] SCK_HALF   = 4'h4;
  localparam logic [3:0] NBITS      = 4'h8;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss_n;
  } ssdr_pin_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } ssdr_state_t;
endpackage

// file: src/ssdr_core.sv
// serial status, flag and data-buffer logic with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
// Operation
// - done flag sets when a byte transfer ends, clears when a master transfer starts
// - done flag raises the interrupt only while interrupt enable is one
// - status access then data read or write clears the done flag
// - data writes ignored while done flag set until status is accessed
// - data write during a running transfer sets the write collision flag
// - new byte arriving with done flag still set sets overrun, may interrupt
// - reading the status register clears overrun
// - select input low while master sets the mode fault flag
// - mode fault raises the interrupt when interrupt enable is one
// - control read while mode fault set, then control write, clears it
// - mode fault clears peripheral enable and master select bits
// - output disable stops driving mosi as master, miso as slave
// - with output disable clear, data output driven only if enabled
// - select management ignores the select pin and uses the internal level
// - internal level zero means selected, one means deselected
// - master data write starts sending and receiving one more byte
// - on the final serial clock the received byte goes to the buffer unless done is still set
// - data read returns the buffer, never the live shift register
// - all three events share one interrupt gated by the common enable
module ssdr_core (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial pins, enables low while driving
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  input  wire logic        ss_n_in,
  // interrupt request
  output logic             irq
);
  logic [7:0] ctrl_r, stat_r, shift_r, rxbuf_r;
  logic       ph_valid_r, ph_write_r;
  logic [7:0] ph_addr_r;
  logic       stat_seen_r, write_collision_flag_seen_r, ctrl_seen_r;
  logic [3:0] bitcnt_r, div_r;
  ssdr_pkg::ssdr_state_t st_r;
  ssdr_pkg::ssdr_pin_t   s1_r, s2_r;
  logic       sck_d_r;

  // synchronise pins, first stage read only by second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= '{mosi: mosi_in, miso: miso_in, sck: sck_in, ss_n: ss_n_in};
      s2_r <= s1_r;
    end
  end

  wire master  = ctrl_r[ssdr_pkg::BIT_MSTR];
  wire pen     = ctrl_r[ssdr_pkg::BIT_PEN];
  wire irq_en  = ctrl_r[ssdr_pkg::BIT_IRQE];
  // software select overrides the pin, zero is selected
  wire sel_lvl = stat_r[ssdr_pkg::BIT_SSM] ? stat_r[ssdr_pkg::BIT_SSI] : s2_r.ss_n;
  wire busy    = (st_r != ssdr_pkg::ST_IDLE);

  // bus decode
  wire acc     = hsel & hready & htrans[1];
  wire do_wr   = ph_valid_r & ph_write_r;
  wire do_rd   = ph_valid_r & ~ph_write_r;
  wire wr_data = do_wr & (ph_addr_r == ssdr_pkg::ADDR_DATA);
  wire rd_data = do_rd & (ph_addr_r == ssdr_pkg::ADDR_DATA);
  wire wr_ctrl = do_wr & (ph_addr_r == ssdr_pkg::ADDR_CTRL);
  wire ac_ctrl = ph_valid_r & (ph_addr_r == ssdr_pkg::ADDR_CTRL);
  wire rd_stat = do_rd & (ph_addr_r == ssdr_pkg::ADDR_STAT);
  wire ac_stat = ph_valid_r & (ph_addr_r == ssdr_pkg::ADDR_STAT);
  wire wr_stat = do_wr & (ph_addr_r == ssdr_pkg::ADDR_STAT);

  // data writes locked while done flag set and status not accessed
  wire wr_lock = stat_r[ssdr_pkg::BIT_DONE] & ~stat_seen_r;
  wire start   = wr_data & ~wr_lock & ~busy & master & pen;
  wire coll    = wr_data & ~wr_lock & busy;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r  <= 8'h00;
    end else if (hready) begin
      ph_valid_r <= acc;
      ph_write_r <= hwrite;
      ph_addr_r  <= {haddr[7:2], 2'b00};
    end
  end

  // read data registered at data phase; buffer, never the shifter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      unique case ({haddr[7:2], 2'b00})
        ssdr_pkg::ADDR_DATA: hrdata <= {24'h00_0000, rxbuf_r};
        ssdr_pkg::ADDR_CTRL: hrdata <= {24'h00_0000, ctrl_r};
        ssdr_pkg::ADDR_STAT: hrdata <= {24'h00_0000, stat_r};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // serial engine events
  wire sck_rise = s2_r.sck & ~sck_d_r;
  wire sck_fall = ~s2_r.sck & sck_d_r;
  wire m_tick   = (div_r == ssdr_pkg::SCK_HALF - 4'h1);
  wire last_bit = (bitcnt_r == ssdr_pkg::NBITS - 4'h1);
  logic byte_end;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sck_d_r <= 1'b0;
    else        sck_d_r <= s2_r.sck;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) div_r <= 4'h0;
    else if (!busy || m_tick) div_r <= 4'h0;
    else div_r <= div_r + 4'h1;
  end

  // master: mode 0 clocking, sample on high, shift on fall
  // slave: external clock edges, selected and enabled only
  wire slv_ok   = pen & ~master & ~sel_lvl;
  wire samp_evt = master ? (st_r == ssdr_pkg::ST_LOW && m_tick) : (slv_ok & sck_rise);
  wire shft_evt = master ? (st_r == ssdr_pkg::ST_HIGH && m_tick) : (slv_ok & sck_fall);
  logic rx_bit_r;
  assign byte_end = shft_evt & last_bit;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= ssdr_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
      rx_bit_r <= 1'b0;
    end else begin
      unique case (st_r)
        ssdr_pkg::ST_IDLE: begin
          bitcnt_r <= 4'h0;
          if (start) begin
            shift_r <= hwdata[7:0];
            st_r    <= ssdr_pkg::ST_LOW;
          end else if (slv_ok && sck_rise) begin
            rx_bit_r <= s2_r.mosi;
            st_r     <= ssdr_pkg::ST_HIGH;
          end else if (wr_data && !wr_lock && !master) begin
            shift_r <= hwdata[7:0];
          end
        end
        ssdr_pkg::ST_LOW: begin
          if (!pen) st_r <= ssdr_pkg::ST_IDLE;
          else if (samp_evt) begin
            rx_bit_r <= master ? s2_r.miso : s2_r.mosi;
            st_r     <= ssdr_pkg::ST_HIGH;
          end
        end
        ssdr_pkg::ST_HIGH: begin
          if (!pen) st_r <= ssdr_pkg::ST_IDLE;
          else if (shft_evt) begin
            shift_r  <= {shift_r[6:0], rx_bit_r};
            bitcnt_r <= bitcnt_r + 4'h1;
            st_r     <= last_bit ? ssdr_pkg::ST_IDLE : ssdr_pkg::ST_LOW;
          end
        end
        default: st_r <= ssdr_pkg::ST_IDLE;
      endcase
    end
  end

  // buffer copy on the final clock, skipped on overrun to keep unread byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rxbuf_r <= 8'h00;
    else if (byte_end && !stat_r[ssdr_pkg::BIT_DONE]) rxbuf_r <= {shift_r[6:0], rx_bit_r};
  end

  // status read arms the clearing sequences
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_seen_r <= 1'b0;
      write_collision_flag_seen_r <= 1'b0;
    end else begin
      if (ac_stat) stat_seen_r <= stat_r[ssdr_pkg::BIT_DONE];
      else if (wr_data || rd_data) stat_seen_r <= 1'b0;
      if (rd_stat) write_collision_flag_seen_r <= stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG];
      else if (rd_data) write_collision_flag_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctrl_seen_r <= 1'b0;
    else if (ac_ctrl && !wr_ctrl) ctrl_seen_r <= stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG];
    else if (wr_ctrl) ctrl_seen_r <= 1'b0;
  end

  wire mode_fault_flag_evt = master & pen & ~sel_lvl;

  // flags: set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= ssdr_pkg::STAT_RST;
    end else begin
      if (byte_end) stat_r[ssdr_pkg::BIT_DONE] <= 1'b1;
      else if (start || (stat_seen_r && (wr_data || rd_data))) stat_r[ssdr_pkg::BIT_DONE] <= 1'b0;
      if (coll) stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
      else if (write_collision_flag_seen_r && rd_data) stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b0;
      if (byte_end && stat_r[ssdr_pkg::BIT_DONE]) stat_r[ssdr_pkg::BIT_OVR] <= 1'b1;
      else if (rd_stat) stat_r[ssdr_pkg::BIT_OVR] <= 1'b0;
      if (mode_fault_flag_evt) stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG] <= 1'b1;
      else if (ctrl_seen_r && wr_ctrl) stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG] <= 1'b0;
      // reserved bit kept zero regardless of software
      stat_r[ssdr_pkg::BIT_RSVD] <= 1'b0;
      if (wr_stat) stat_r[2:0] <= hwdata[2:0] & ssdr_pkg::STAT_WMASK[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctrl_r <= ssdr_pkg::CTRL_RST;
    else begin
      if (wr_ctrl) ctrl_r <= hwdata[7:0] & ssdr_pkg::CTRL_WMASK;
      if (mode_fault_flag_evt) begin
        ctrl_r[ssdr_pkg::BIT_PEN]  <= 1'b0;
        ctrl_r[ssdr_pkg::BIT_MSTR] <= 1'b0;
      end
    end
  end

  // shared interrupt line
  assign irq = irq_en & (stat_r[ssdr_pkg::BIT_DONE] | stat_r[ssdr_pkg::BIT_OVR]
                       | stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG]);

  // pins
  wire out_en = pen & ~stat_r[ssdr_pkg::BIT_SOD];
  assign sck_out   = (st_r == ssdr_pkg::ST_HIGH) & master;
  assign sck_oe_n  = ~(pen & master);
  assign mosi_out  = shift_r[7];
  assign mosi_oe_n = ~(out_en & master);
  assign miso_out  = shift_r[7];
  assign miso_oe_n = ~(out_en & ~master & ~sel_lvl);

  a_done_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    byte_end |=> stat_r[ssdr_pkg::BIT_DONE]) else $error("done flag not set");
  a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    irq |-> ctrl_r[ssdr_pkg::BIT_IRQE]) else $error("irq without enable");
  a_done_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat_seen_r && rd_data && !byte_end) |=> !stat_r[ssdr_pkg::BIT_DONE]) else $error("done not cleared");
  a_write_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_data && wr_lock) |=> $stable(st_r)) else $error("locked write acted");
  a_write_collision_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
    coll |=> stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG]) else $error("collision missed");
  a_ovr_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (byte_end && stat_r[ssdr_pkg::BIT_DONE]) |=> stat_r[ssdr_pkg::BIT_OVR]) else $error("overrun missed");
  a_ovr_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stat && !byte_end) |=> !stat_r[ssdr_pkg::BIT_OVR]) else $error("overrun not cleared");
  a_mode_fault_flag_ctrl: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_fault_flag_evt |=> stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG] && !ctrl_r[ssdr_pkg::BIT_PEN]
      && !ctrl_r[ssdr_pkg::BIT_MSTR]) else $error("mode fault handling wrong");
  a_sod_off: assert property (@(posedge mclk) disable iff (!rst_n)
    stat_r[ssdr_pkg::BIT_SOD] |-> mosi_oe_n && miso_oe_n) else $error("output driven while disabled");


  // flags hold until their own clearing sequence, so software never loses an event
  a_done_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat_r[ssdr_pkg::BIT_DONE] && !start && !(stat_seen_r && (wr_data || rd_data))) |=> stat_r[ssdr_pkg::BIT_DONE])
    else $error("done flag dropped");
  a_start_xfer: assert property (@(posedge mclk) disable iff (!rst_n)
    start |=> (st_r == ssdr_pkg::ST_LOW) && !stat_r[ssdr_pkg::BIT_DONE])
    else $error("master write did not start");
  a_write_collision_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG] && !(write_collision_flag_seen_r && rd_data)) |=> stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag dropped");
  a_write_collision_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (write_collision_flag_seen_r && rd_data) |=> !stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag not cleared");
  a_write_collision_flag_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (!stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG] && !coll) |=> !stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag without collision");
  a_ovr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat_r[ssdr_pkg::BIT_OVR] && !rd_stat) |=> stat_r[ssdr_pkg::BIT_OVR])
    else $error("overrun dropped");
  a_ovr_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (!stat_r[ssdr_pkg::BIT_OVR] && !(byte_end && stat_r[ssdr_pkg::BIT_DONE])) |=> !stat_r[ssdr_pkg::BIT_OVR])
    else $error("overrun without cause");
  a_mode_fault_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG] && !(ctrl_seen_r && wr_ctrl)) |=> stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault dropped");
  a_mode_fault_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctrl_seen_r && wr_ctrl && !mode_fault_flag_evt) |=> !stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG])
    else $error("mode fault not cleared");

  // receive buffer moves only on an accepted copy
  a_buf_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    !(byte_end && !stat_r[ssdr_pkg::BIT_DONE]) |=> $stable(rxbuf_r))
    else $error("buffer changed outside copy");
  a_rdata_buf: assert property (@(posedge mclk) disable iff (!rst_n)
    (acc && !hwrite && ({haddr[7:2], 2'b00} == ssdr_pkg::ADDR_DATA)) |=> hrdata[7:0] == $past(rxbuf_r))
    else $error("data read not from buffer");
  a_bitcnt_max: assert property (@(posedge mclk) disable iff (!rst_n)
    bitcnt_r <= 4'h8)
    else $error("bit counter out of range");

  // one shared request line
  a_irq_source: assert property (@(posedge mclk) disable iff (!rst_n)
    irq |-> (stat_r[ssdr_pkg::BIT_DONE] || stat_r[ssdr_pkg::BIT_OVR] || stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG]))
    else $error("irq without event");
  a_irq_done: assert property (@(posedge mclk) disable iff (!rst_n)
    (irq_en && stat_r[ssdr_pkg::BIT_DONE]) |-> irq)
    else $error("done irq missing");
  a_irq_mode_fault_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (irq_en && stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG]) |-> irq)
    else $error("mode fault irq missing");

  // pin drivers
  a_out_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    (pen && master && !stat_r[ssdr_pkg::BIT_SOD]) |-> !mosi_oe_n)
    else $error("mosi not driven");
  a_out_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !pen |-> (mosi_oe_n && miso_oe_n))
    else $error("output driven while disabled");
  a_miso_master: assert property (@(posedge mclk) disable iff (!rst_n)
    master |-> miso_oe_n)
    else $error("miso driven as master");
  a_mosi_slave: assert property (@(posedge mclk) disable iff (!rst_n)
    !master |-> mosi_oe_n)
    else $error("mosi driven as slave");
  a_slave_desel: assert property (@(posedge mclk) disable iff (!rst_n)
    (!master && stat_r[ssdr_pkg::BIT_SSM] && stat_r[ssdr_pkg::BIT_SSI]) |-> miso_oe_n)
    else $error("deselected slave drives");
  a_slave_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    (pen && !master && !stat_r[ssdr_pkg::BIT_SOD] && stat_r[ssdr_pkg::BIT_SSM] && !stat_r[ssdr_pkg::BIT_SSI])
      |-> !miso_oe_n)
    else $error("selected slave silent");
  a_sck_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !busy |-> !sck_out)
    else $error("clock runs while idle");
  a_bus_okay: assert property (@(posedge mclk) disable iff (!rst_n)
    hreadyout && !hresp)
    else $error("bus response not okay");

  c_master_byte: cover property (@(posedge mclk) disable iff (!rst_n) start ##[1:200] byte_end);
  c_slave_byte: cover property (@(posedge mclk) disable iff (!rst_n) slv_ok && byte_end);
  c_collision: cover property (@(posedge mclk) disable iff (!rst_n) $rose(stat_r[ssdr_pkg::BIT_WRITE_COLLISION_FLAG]));
  c_overrun: cover property (@(posedge mclk) disable iff (!rst_n) $rose(stat_r[ssdr_pkg::BIT_OVR]));
  c_mode_fault_flag: cover property (@(posedge mclk) disable iff (!rst_n) $rose(stat_r[ssdr_pkg::BIT_MODE_FAULT_FLAG]));
endmodule // ssdr_core
`default_nettype wire

// file: dv/ssdr_slave_model.sv
// far-side serial slave model: mode 0, msb first, answers from tx
`timescale 1ns/100ps
`default_nettype none
module ssdr_slave_model (
  // serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  output var  logic       miso,
  // bench side
  input  wire logic       sel,
  input  wire logic [7:0] tx,
  output var  logic [7:0] rx,
  output var  logic [7:0] count
);
  logic [7:0] sh;
  logic [2:0] n;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    count = 8'h00;
    sh = 8'h00;
    n = 3'h0;
  end
  always @(posedge sel) begin
    sh = tx;
    miso = tx[7];
    n = 3'h0;
  end
  // released line must not keep showing the last bit
  always @(negedge sel) miso = ~miso;
  always @(posedge sck) if (sel) begin
    rx = {rx[6:0], mosi};
    n = n + 3'h1;
    if (n == 3'h0) count = count + 8'h01;
  end
  always @(negedge sck) if (sel) begin
    sh = (n == 3'h0) ? tx : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule // ssdr_slave_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench: ahb-lite register master, serial master and slave traffic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq, sel;
  logic [7:0]  haddr, ptx, prx, pcnt;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, pmiso;
  logic        sck_drv, mosi_drv, ss_n;
  wire logic   sck_w  = sck_oe_n ? sck_drv : sck_out;
  wire logic   mosi_w = mosi_oe_n ? mosi_drv : mosi_out;
  wire logic   miso_w = miso_oe_n ? pmiso : miso_out;
  int          err_count, checked;
  ssdr_core ssdr_core_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n), .irq(irq));
  ssdr_slave_model ssdr_slave_model_i (.sck(sck_w), .mosi(mosi_w), .miso(pmiso), .sel(sel),
    .tx(ptx), .rx(prx), .count(pcnt));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic summarize;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // only the watchdog ends a stalled wait
  task automatic wt;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= a; hwrite <= w; htrans <= 2'h2; hsize <= 3'h2;
    wt();
    htrans <= 2'h0; hwdata <= d;
    wt();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, r);
    chk(32'h0, {31'h0, hresp});
  endtask
  task automatic wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin @(posedge mclk); n++; end
    chk(32'h1, {31'h0, irq});
  endtask
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi_drv <= b[i]; repeat (4) @(posedge mclk);
      sck_drv <= 1'b1; repeat (4) @(posedge mclk);
      sck_drv <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic t_reset;
    rd(ssdr_pkg::ADDR_CTRL, 32'h0);
    rd(ssdr_pkg::ADDR_STAT, 32'h0);
    rd(8'h0c, 32'h0);  // unmapped place reads zero
    $display("test reset done");
  endtask
  task automatic t_master;
    ptx <= 8'h3c; sel <= 1'b1;
    bus(1'b1, ssdr_pkg::ADDR_CTRL, 32'hd0);
    bus(1'b1, ssdr_pkg::ADDR_STAT, 32'h00);
    @(negedge mclk);
    chk(32'h0, {31'h0, mosi_oe_n});
    @(posedge mclk);
    bus(1'b1, ssdr_pkg::ADDR_DATA, 32'ha5);
    rd(ssdr_pkg::ADDR_STAT, 32'h00);
    wirq();
    bus(1'b1, ssdr_pkg::ADDR_DATA, 32'h11);
    repeat (100) @(posedge mclk);
    chk(32'h1, {24'h0, pcnt});
    rd(ssdr_pkg::ADDR_STAT, 32'h80);
    rd(ssdr_pkg::ADDR_DATA, 32'h3c);
    chk(32'ha5, {24'h0, prx});
    rd(ssdr_pkg::ADDR_STAT, 32'h00);
    bus(1'b1, ssdr_pkg::ADDR_DATA, 32'h66);
    bus(1'b1, ssdr_pkg::ADDR_DATA, 32'h77);
    rd(ssdr_pkg::ADDR_STAT, 32'h40);
    wirq();
    rd(ssdr_pkg::ADDR_STAT, 32'hc0);
    rd(ssdr_pkg::ADDR_DATA, 32'h3c);
    rd(ssdr_pkg::ADDR_STAT, 32'h00);
    bus(1'b1, ssdr_pkg::ADDR_STAT, 32'h04);
    repeat (2) @(posedge mclk);
    chk(32'h1, {31'h0, mosi_oe_n});
    bus(1'b1, ssdr_pkg::ADDR_STAT, 32'h00);
    sel <= 1'b0;
    $display("test master done");
  endtask
  task automatic t_mode_fault_flag;
    ss_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(32'h1, {31'h0, irq});
    rd(ssdr_pkg::ADDR_STAT, 32'h10);
    rd(ssdr_pkg::ADDR_CTRL, 32'h80);
    bus(1'b1, ssdr_pkg::ADDR_CTRL, 32'h80);
    rd(ssdr_pkg::ADDR_STAT, 32'h00);
    $display("test mode_fault_flag done");
  endtask
  task automatic t_slave;
    bus(1'b1, ssdr_pkg::ADDR_CTRL, 32'hc0);
    repeat (4) @(posedge mclk);
    chk(32'h0, {31'h0, miso_oe_n});
    sbyte(8'h5a);
    sbyte(8'hc3);
    rd(ssdr_pkg::ADDR_STAT, 32'ha0);
    chk(32'h1, {31'h0, irq});
    rd(ssdr_pkg::ADDR_STAT, 32'h80);
    rd(ssdr_pkg::ADDR_DATA, 32'h5a);
    rd(ssdr_pkg::ADDR_STAT, 32'h00);
    bus(1'b1, ssdr_pkg::ADDR_DATA, 32'h80);
    @(negedge mclk);
    chk(32'h1, {31'h0, miso_out});
    @(posedge mclk);
    bus(1'b1, ssdr_pkg::ADDR_STAT, 32'h03);
    sbyte(8'h44);
    rd(ssdr_pkg::ADDR_STAT, 32'h03);
    bus(1'b1, ssdr_pkg::ADDR_STAT, 32'h02);
    ss_n <= 1'b1;
    sbyte(8'h99);
    rd(ssdr_pkg::ADDR_STAT, 32'h82);
    rd(ssdr_pkg::ADDR_DATA, 32'h99);
    $display("test slave done");
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    summarize();
  end
  initial begin
    rst_n = 1'b0; hsel = 1'b1; hwrite = 1'b0; haddr = 8'h00; htrans = 2'h0; hsize = 3'h2;
    hwdata = 32'h0; sck_drv = 1'b0; mosi_drv = 1'b0; ss_n = 1'b1; sel = 1'b0; ptx = 8'h00;
    err_count = 0; checked = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_master();
    t_mode_fault_flag();
    t_slave();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
